// file: sccd_pkg.sv
package sccd_pkg;
  // --------
  // framing byte fields
  // --------
  localparam int LineLsb = 0;
  localparam int WordLsb = 2;
  localparam int ParLsb = 4;
  localparam int StopLsb = 6;
  localparam logic [7:0] FramingDefault = 8'h4c; // rs232, 8 bit, no parity, 1 stop
  localparam logic [1:0] LineRs232 = 2'h0;
  localparam logic [1:0] LineRs422 = 2'h1;
  localparam logic [1:0] LineRs485w2 = 2'h3;
  localparam logic [1:0] Word7 = 2'h2;
  localparam logic [1:0] Word8 = 2'h3;
  localparam logic [1:0] ParNone = 2'h0;
  localparam logic [1:0] ParOdd = 2'h1;
  localparam logic [1:0] ParEven = 2'h3;
  localparam logic [1:0] Stop1 = 2'h1;
  localparam logic [1:0] Stop2 = 2'h3;
  // --------
  // flow control codes
  // --------
  localparam logic [7:0] FlowNone = 8'h00;
  localparam logic [7:0] FlowXon = 8'h01;
  localparam logic [7:0] FlowRtsCts = 8'h02;
  localparam logic [7:0] FlowXonPass = 8'h05;
  // --------
  // ports
  // --------
  localparam logic [15:0] PortDefaultCh1 = 16'h2711; // 10001
  localparam logic [15:0] PortDefaultCh2 = 16'h2712; // 10002
  localparam logic [15:0] AutoPortLow = 16'hc350; // 50000
  localparam logic [15:0] AutoPortHigh = 16'hea5f; // 59999
  // --------
  // connection policy byte
  // --------
  localparam logic [7:0] PolicyDefault = 8'hc0;
  localparam logic [2:0] AcceptNever = 3'h0;
  localparam logic [2:0] AcceptModem = 3'h2;
  localparam logic [2:0] AcceptAlways = 3'h6;
  localparam logic [3:0] StartNone = 4'h0;
  localparam logic [3:0] StartAnyChar = 4'h1;
  localparam logic [3:0] StartModemIn = 4'h2;
  localparam logic [3:0] StartChar = 4'h3;
  localparam logic [3:0] StartManual = 4'h4;
  localparam logic [3:0] StartAuto = 4'h5;
  localparam logic [3:0] StartUdp = 4'hc;
  localparam logic [3:0] HostlistHigh = 4'h2;
  localparam logic [7:0] StartCharDefault = 8'h0d;
  localparam logic [7:0] RespConnected = 8'h43; // C
  localparam logic [7:0] RespDisconnected = 8'h44; // D
  localparam logic [7:0] RespUnreachable = 8'h4e; // N

  typedef enum logic [1:0] {
    SCCD_LINE_RS232 = 2'h0,
    SCCD_LINE_RS422 = 2'h1,
    SCCD_LINE_RS485W2 = 2'h3
  } sccd_line_t;

  typedef enum logic [2:0] {
    SCCD_START_NONE, SCCD_START_ANY, SCCD_START_MODEM_IN, SCCD_START_CHAR,
    SCCD_START_MANUAL, SCCD_START_AUTO, SCCD_START_UDP
  } sccd_start_t;

  typedef enum logic [2:0] {
    SCCD_MDM_OFF, SCCD_MDM_NO_ECHO, SCCD_MDM_ECHO_NUM, SCCD_MDM_ECHO_VERB,
    SCCD_MDM_RESP_NUM, SCCD_MDM_RESP_VERB
  } sccd_modem_t;

  // decoded serial framing
  typedef struct packed {
    logic [1:0] line;
    logic eightBit;
    logic parityEn;
    logic parityOdd;
    logic twoStop;
    logic [1:0] flow;
  } sccd_frame_t;

  // decoded connection policy
  typedef struct packed {
    logic [2:0] accept;
    logic charResp;
    logic [2:0] start;
    logic hostlist;
    logic [2:0] modem;
  } sccd_policy_t;

  // connection state events from the network engine
  typedef struct packed {
    logic connected;
    logic disconnected;
    logic unreachable;
  } sccd_event_t;
endpackage

// file: sccd_channel_config.sv
`timescale 1ns/1ns
// Behaviour
// - framing bits 1:0 choose line type
// - bits 3:2 word length, 5:4 parity
// - bits 7:6 stop bits, two by firmware
// - framing default 0x4c
// - flow code none, xon, rtscts, xon-pass
// - local port defaults 10001/10002
// - port zero: source port 50000..59999 incrementing
// - policy default 0xc0, bits 7:5 accept
// - never-accept refuses all incoming
// - conditional accept needs modem input, not modem mode
// - always-accept when not already connected
// - bit 4 sends c, d, n characters
// - responses ignored in modem/hostlist; verbose shows ip
// - bits 3:0 choose active startup
// - modem emulation on bits 2:1 with bit 5 clear
// - modem input rising edge starts connect
// - start character begins connect, default cr
module sccd_channel_config #(
  parameter bit SecondChannel = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // avalon-mm slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // serial side
  input wire logic modemCtrlIn,
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  output logic respValid,
  output logic [7:0] respChar,
  output logic respShowAddr,
  // network side
  input wire logic incomingReq,
  input wire logic connActive,
  input wire sccd_pkg::sccd_event_t connEvent,
  input wire logic outConnOpen,
  output logic incomingAccept,
  output logic incomingRefuse,
  output logic connectStart,
  output logic [15:0] srcPort,
  output sccd_pkg::sccd_frame_t frameCfg,
  output sccd_pkg::sccd_policy_t policyCfg
);
  import sccd_pkg::*;

  // --------
  // register map
  // --------
  localparam logic [3:0] RegFraming = 4'h0;
  localparam logic [3:0] RegFlow = 4'h1;
  localparam logic [3:0] RegPort = 4'h2;
  localparam logic [3:0] RegPolicy = 4'h3;
  localparam logic [3:0] RegStartChar = 4'h4;
  localparam logic [3:0] RegStatus = 4'h5;

  // --------
  // reset and pin synchronisers
  // --------
  logic [1:0] rstSync; // reset release chain
  logic rstnInt; // synchronised reset
  logic modemMeta; // first stage, read only by modemSync
  logic modemSync; // second stage
  logic modemPrev; // for edge detect

  // release reset through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnInt = rstSync[1];

  // modem control comes from a pin
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      modemMeta <= 1'b0;
      modemSync <= 1'b0;
      modemPrev <= 1'b0;
    end else if (clkEn) begin
      modemMeta <= modemCtrlIn;
      modemSync <= modemMeta;
      modemPrev <= modemSync;
    end
  end

  // --------
  // configuration registers
  // --------
  logic [7:0] framing_q; // framing byte
  logic [7:0] flow_q; // flow code
  logic [15:0] port_q; // local port
  logic [7:0] policy_q; // connection_policy_byte
  logic [7:0] startChar_q; // start character
  logic wrHit; // write strobe this cycle

  // byte-lane merge
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be);
    laneMerge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // a write lands only at the edge that sees waitrequest low
  assign wrHit = avsWrite && !avsWaitrequest;

  // software writes
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      framing_q <= FramingDefault;
      flow_q <= FlowNone;
      port_q <= SecondChannel ? PortDefaultCh2 : PortDefaultCh1;
      policy_q <= PolicyDefault;
      startChar_q <= StartCharDefault;
    end else if (clkEn && wrHit) begin
      case (avsAddress)
        RegFraming: if (avsByteenable[0]) framing_q <= avsWritedata[7:0];
        RegFlow: if (avsByteenable[0]) flow_q <= avsWritedata[7:0];
        RegPort: port_q <= laneMerge(port_q, avsWritedata[15:0], avsByteenable[1:0]);
        RegPolicy: if (avsByteenable[0]) policy_q <= avsWritedata[7:0];
        RegStartChar: if (avsByteenable[0]) startChar_q <= avsWritedata[7:0];
        default: ; // unmapped writes dropped
      endcase
    end
  end

  // --------
  // framing and flow decode
  // --------
  sccd_frame_t frame_d;
  always_comb begin
    frame_d = '0;
    // line type, 2'h2 invalid falls back to rs232
    case (framing_q[LineLsb +: 2])
      LineRs422: frame_d.line = LineRs422;
      LineRs485w2: frame_d.line = LineRs485w2;
      default: frame_d.line = LineRs232;
    endcase
    // word length; invalid codes keep eight bits
    frame_d.eightBit = (framing_q[WordLsb +: 2] != Word7);
    // parity; 2'h2 invalid means none
    case (framing_q[ParLsb +: 2])
      ParOdd: begin
        frame_d.parityEn = 1'b1;
        frame_d.parityOdd = 1'b1;
      end
      ParEven: frame_d.parityEn = 1'b1;
      default: frame_d.parityEn = 1'b0;
    endcase
    // two stop bits cost throughput: the serial engine does them slowly
    frame_d.twoStop = (framing_q[StopLsb +: 2] == Stop2);
    case (flow_q)
      FlowXon: frame_d.flow = 2'h1;
      FlowRtsCts: frame_d.flow = 2'h2;
      FlowXonPass: frame_d.flow = 2'h3;
      default: frame_d.flow = 2'h0;
    endcase
  end

  // --------
  // policy decode
  // --------
  sccd_policy_t policy_d;
  always_comb begin
    policy_d = '0;
    policy_d.hostlist = (policy_q[7:4] == HostlistHigh);
    // modem emulation: bits 2:1 set, bit 5 clear
    if (policy_q[2:1] == 2'h3 && !policy_q[5]) begin
      if (policy_q[4]) begin
        policy_d.modem = policy_q[0] ? SCCD_MDM_ECHO_NUM : SCCD_MDM_ECHO_VERB;
      end else if (policy_q[3]) begin
        policy_d.modem = policy_q[0] ? SCCD_MDM_RESP_NUM : SCCD_MDM_RESP_VERB;
      end else begin
        policy_d.modem = SCCD_MDM_NO_ECHO;
      end
    end
    // acceptance; hostlist refuses data connections
    case (policy_q[7:5])
      AcceptModem: policy_d.accept = AcceptModem;
      AcceptAlways: policy_d.accept = AcceptAlways;
      AcceptNever: policy_d.accept = AcceptNever;
      default: policy_d.accept = policy_d.hostlist ? AcceptNever : AcceptAlways;
    endcase
    // conditional accept is not allowed with modem emulation
    if (policy_d.accept == AcceptModem && policy_d.modem != SCCD_MDM_OFF) begin
      policy_d.accept = AcceptNever;
    end
    // responses suppressed under modem or hostlist startup
    policy_d.charResp = policy_q[4] && !policy_d.hostlist
                        && policy_d.modem == SCCD_MDM_OFF;
    case (policy_q[3:0])
      StartNone: policy_d.start = SCCD_START_NONE;
      StartAnyChar: policy_d.start = SCCD_START_ANY;
      StartModemIn: policy_d.start = SCCD_START_MODEM_IN;
      StartChar: policy_d.start = SCCD_START_CHAR;
      StartManual: policy_d.start = SCCD_START_MANUAL;
      StartAuto: policy_d.start = SCCD_START_AUTO;
      StartUdp: policy_d.start = SCCD_START_UDP;
      default: policy_d.start = SCCD_START_NONE;
    endcase
    if (policy_d.modem != SCCD_MDM_OFF) begin
      policy_d.start = SCCD_START_NONE; // modem bits overlap startup field
    end
  end

  // --------
  // incoming connection arbitration
  // --------
  logic acceptNow;
  always_comb begin
    case (policy_d.accept)
      AcceptModem: acceptNow = modemSync && !connActive;
      AcceptAlways: acceptNow = !connActive;
      default: acceptNow = 1'b0;
    endcase
  end

  // one-cycle answer to each incoming request
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      incomingAccept <= 1'b0;
      incomingRefuse <= 1'b0;
    end else if (clkEn) begin
      incomingAccept <= incomingReq && acceptNow;
      incomingRefuse <= incomingReq && !acceptNow;
    end
  end

  // --------
  // active startup
  // --------
  logic startTrig;
  logic autoFired; // autostart fires once after reset
  always_comb begin
    case (policy_d.start)
      SCCD_START_ANY: startTrig = rxCharValid;
      SCCD_START_MODEM_IN: startTrig = modemSync && !modemPrev;
      SCCD_START_CHAR: startTrig = rxCharValid && rxChar == startChar_q;
      SCCD_START_AUTO: startTrig = !autoFired;
      default: startTrig = 1'b0; // manual parsing and udp handled elsewhere
    endcase
  end

  // connect pulse; suppressed while a link is up
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      connectStart <= 1'b0;
      autoFired <= 1'b0;
    end else if (clkEn) begin
      connectStart <= startTrig && !connActive;
      if (policy_d.start == SCCD_START_AUTO && !connActive) begin
        autoFired <= 1'b1;
      end
    end
  end

  // --------
  // source port selection
  // --------
  logic [15:0] autoPort_q; // next automatic source port
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      autoPort_q <= AutoPortLow;
    end else if (clkEn && outConnOpen && port_q == 16'h0000) begin
      // wrap at the top of the range
      autoPort_q <= (autoPort_q >= AutoPortHigh) ? AutoPortLow : autoPort_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      srcPort <= SecondChannel ? PortDefaultCh2 : PortDefaultCh1;
    end else if (clkEn) begin
      srcPort <= (port_q == 16'h0000) ? autoPort_q : port_q;
    end
  end

  // --------
  // character responses
  // --------
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      respValid <= 1'b0;
      respChar <= 8'h00;
      respShowAddr <= 1'b0;
    end else if (clkEn) begin
      respValid <= policy_d.charResp && |connEvent;
      // priority: connect, then disconnect, then unreachable
      if (connEvent.connected) begin
        respChar <= RespConnected;
      end else if (connEvent.disconnected) begin
        respChar <= RespDisconnected;
      end else if (connEvent.unreachable) begin
        respChar <= RespUnreachable;
      end
      // verbose modem modes show the peer address
      respShowAddr <= connEvent.connected && (policy_d.modem == SCCD_MDM_ECHO_VERB
                      || policy_d.modem == SCCD_MDM_RESP_VERB);
    end
  end

  // --------
  // decoded outputs and bus answer
  // --------
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      frameCfg <= '0;
      policyCfg <= '0;
    end else if (clkEn) begin
      frameCfg <= frame_d;
      policyCfg <= policy_d;
    end
  end

  // one wait state per access; read data stands while waitrequest is low
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= 32'h0000_0000;
    end else if (clkEn) begin
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
      if (avsRead && avsWaitrequest) begin
        case (avsAddress)
          RegFraming: avsReaddata <= {24'h0, framing_q};
          RegFlow: avsReaddata <= {24'h0, flow_q};
          RegPort: avsReaddata <= {16'h0, port_q};
          RegPolicy: avsReaddata <= {24'h0, policy_q};
          RegStartChar: avsReaddata <= {24'h0, startChar_q};
          RegStatus: avsReaddata <= {autoPort_q, 4'h0, modemSync, connActive, 2'h0, frame_d};
          default: avsReaddata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // sccd_channel_config

// file: sccd_cfg_asserts.sv
`timescale 1ns/1ns
module sccd_cfg_asserts
  import sccd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] avsAddress,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic avsWaitrequest,
  input wire logic modemCtrlIn,
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic respValid,
  input wire logic [7:0] respChar,
  input wire logic incomingReq,
  input wire logic connActive,
  input wire sccd_event_t connEvent,
  input wire logic outConnOpen,
  input wire logic incomingAccept,
  input wire logic incomingRefuse,
  input wire logic connectStart,
  input wire logic [15:0] srcPort,
  input wire sccd_frame_t frameCfg,
  input wire sccd_policy_t policyCfg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // --------
  // helper: framing byte taken by the bus
  // --------
  logic wrFr; // write to framing byte completes this edge
  logic [7:0] frB_q; // last framing byte written
  assign wrFr = avsWrite && !avsWaitrequest && avsAddress == 4'h0 && avsByteenable[0];
  // capture only on the completing edge, so a held request counts once
  always_ff @(posedge core_clk) begin
    if (wrFr) begin
      frB_q <= avsWritedata[7:0];
    end
  end
  // --------
  // properties
  // --------
  property p_oneAnswer;
    incomingReq |=> $onehot({incomingAccept, incomingRefuse});
  endproperty
  property p_never;
    incomingReq && policyCfg.accept == AcceptNever |=> incomingRefuse;
  endproperty
  property p_always;
    incomingReq && policyCfg.accept == AcceptAlways && !connActive |=> incomingAccept;
  endproperty
  property p_busy;
    incomingReq && connActive |=> !incomingAccept;
  endproperty
  property p_respConn;
    connEvent.connected && policyCfg.charResp |=> respValid && respChar == RespConnected;
  endproperty
  property p_respCause;
    respValid |-> $past(policyCfg.charResp) && $past(|connEvent);
  endproperty
  property p_port;
    outConnOpen && srcPort >= AutoPortLow && srcPort <= AutoPortHigh |-> ##2 srcPort ==
      (($past(srcPort) == AutoPortHigh) ? AutoPortLow : $past(srcPort) + 16'h1);
  endproperty
  property p_frameLine;
    wrFr |-> ##2 frameCfg.line == ((frB_q[1:0] == 2'h2) ? LineRs232 : frB_q[1:0]);
  endproperty
  property p_frameStop;
    wrFr |-> ##2 frameCfg.twoStop == (frB_q[7:6] == Stop2)
      && frameCfg.eightBit == (frB_q[3:2] != Word7);
  endproperty
  property p_startChar;
    rxCharValid && rxChar == StartCharDefault && policyCfg.start == SCCD_START_CHAR
      && !connActive |-> ##[1:3] connectStart;
  endproperty
  property p_modemStart;
    $rose(modemCtrlIn) && policyCfg.start == SCCD_START_MODEM_IN && !connActive
      |-> ##[2:6] connectStart;
  endproperty
  a_oneAnswer: assert property (p_oneAnswer) else $error("no single answer");
  a_never: assert property (p_never) else $error("never not refused");
  a_always: assert property (p_always) else $error("always not accepted");
  a_busy: assert property (p_busy) else $error("accepted while busy");
  a_respConn: assert property (p_respConn) else $error("no connect char");
  a_respCause: assert property (p_respCause) else $error("stray char");
  a_port: assert property (p_port) else $error("source port step");
  a_frameLine: assert property (p_frameLine) else $error("line decode");
  a_frameStop: assert property (p_frameStop) else $error("stop decode");
  a_startChar: assert property (p_startChar) else $error("start char");
  a_modemStart: assert property (p_modemStart) else $error("modem start");
  c_accept: cover property (incomingAccept);
  c_start: cover property (connectStart);
  c_disc: cover property (respValid && respChar == RespDisconnected);
endmodule // sccd_cfg_asserts

// file: sccd_net_model.sv
`timescale 1ns/1ns
module sccd_net_model
  import sccd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic doOpen,
  input wire logic doDrop,
  input wire logic doUnr,
  input wire logic doReq,
  input wire logic slow,
  input wire logic connectStart,
  input wire logic incomingAccept,
  output logic incomingReq,
  output logic connActive,
  output logic outConnOpen,
  output sccd_event_t connEvent
);
  logic [1:0] cnt_q; // cycles left until a pending open completes
  // --------
  // pending outgoing open; slow stretches setup like a distant host
  // --------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
    end else if (doOpen || connectStart) begin
      cnt_q <= slow ? 2'h3 : 2'h1;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
  // --------
  // event pulses and link state seen by the channel
  // --------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outConnOpen <= 1'b0;
      incomingReq <= 1'b0;
      connEvent <= '0;
      connActive <= 1'b0;
    end else begin
      outConnOpen <= cnt_q == 2'h1;
      incomingReq <= doReq;
      connEvent <= '{connected: cnt_q == 2'h1 || incomingAccept, disconnected: doDrop,
                     unreachable: doUnr};
      // a drop wins over a late open
      if (doDrop) begin
        connActive <= 1'b0;
      end else if (cnt_q == 2'h1 || incomingAccept) begin
        connActive <= 1'b1;
      end
    end
  end
endmodule // sccd_net_model

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sccd_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic [3:0] avsByteenable = 4'hf;
  logic avsRead = 1'b0, avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, rd;
  logic avsWaitrequest, respValid, respShowAddr, incomingReq, connActive, outConnOpen;
  logic incomingAccept, incomingRefuse, connectStart;
  logic modemCtrlIn = 1'b0, rxCharValid = 1'b0;
  logic [7:0] rxChar = 8'h0, respChar, sChar, b;
  logic [15:0] srcPort;
  sccd_event_t connEvent;
  sccd_frame_t frameCfg;
  sccd_policy_t policyCfg;
  logic doOpen = 1'b0, doDrop = 1'b0, doUnr = 1'b0, doReq = 1'b0, slow = 1'b0;
  logic sAcc, sRef, sStart, sResp, sShow; // flags seen during a watch
  int fails = 0, n_checks = 0, seed = 32'h57ea, tmp;
  logic [7:0] ap [7] = '{8'h00, 8'h40, 8'h40, 8'hc0, 8'ha0, 8'h20, 8'h46};
  logic [7:0] sp [7] = '{8'hc0, 8'hc1, 8'hc3, 8'hc3, 8'hc4, 8'hcc, 8'hc2};
  logic [7:0] sc [7] = '{8'h41, 8'h41, 8'h41, 8'h0d, 8'h0d, 8'h0d, 8'h00};
  logic [15:0] dv [5] = '{16'h4c, 16'h00, 16'h2711, 16'hc0, 16'h0d}; // reset values
  localparam logic [6:0] AM = 7'b1000100; // modem input per accept case
  localparam logic [6:0] AE = 7'b0011100; // accept expected per case
  localparam logic [6:0] SE = 7'b1001010; // connect start expected per case
  always #20 core_clk = ~core_clk;
  sccd_channel_config i_dut (.core_clk, .rstn, .clkEn, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest, .modemCtrlIn, .rxCharValid,
    .rxChar, .respValid, .respChar, .respShowAddr, .incomingReq, .connActive, .connEvent,
    .outConnOpen, .incomingAccept, .incomingRefuse, .connectStart, .srcPort, .frameCfg,
    .policyCfg);
  sccd_net_model i_net (.core_clk, .rstn, .doOpen, .doDrop, .doUnr, .doReq, .slow,
    .connectStart, .incomingAccept, .incomingReq, .connActive, .outConnOpen, .connEvent);
  // --------
  // helpers
  // --------
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, m);
      fails++;
    end
  endtask
  // avalon master: hold until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    @(posedge core_clk);
    while (avsWaitrequest !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > 50) begin
        fails++;
        complete_run();
      end
    end
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask
  task pol(input logic [7:0] v);
    bus(1'b1, 4'h3, {24'h0, v});
    repeat (4) @(posedge core_clk);
  endtask
  // one pulse to the network model: 0 open, 1 drop, 2 unreachable, 3 incoming
  task cmd(input int k);
    doOpen <= k == 0;
    doDrop <= k == 1;
    doUnr <= k == 2;
    doReq <= k == 3;
    @(posedge core_clk);
    {doOpen, doDrop, doUnr, doReq} <= 4'h0;
    @(posedge core_clk);
  endtask
  task watch(input int n);
    {sAcc, sRef, sStart, sResp, sShow} = 5'h0;
    repeat (n) begin
      @(negedge core_clk);
      sAcc |= incomingAccept;
      sRef |= incomingRefuse;
      sStart |= connectStart;
      sResp |= respValid;
      sShow |= respShowAddr;
      if (respValid === 1'b1) sChar = respChar;
    end
    @(posedge core_clk);
  endtask
  function automatic logic [5:0] fexp(input logic [7:0] v);
    logic [1:0] ln;
    ln = (v[1:0] == 2'h2) ? LineRs232 : v[1:0];
    return {ln, v[3:2] != Word7, v[4], v[5:4] == ParOdd, v[7:6] == Stop2};
  endfunction
  // --------
  // main sequence
  // --------
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(srcPort, PortDefaultCh1, "reset port");
    chk(frameCfg[7:2], fexp(FramingDefault), "reset frame");
    chk(policyCfg.accept, AcceptAlways, "reset accept");
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      chk(rd, {16'h0, dv[i]}, "reset register");
    end
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b0, 4'h5, 32'h0);
    chk(rd, {AutoPortLow, 8'h00, fexp(FramingDefault), 2'h0}, "status");
    $display("test reset done");
    // framing: corners then random bytes
    for (int i = 0; i < 24; i++) begin
      tmp = $random(seed);
      b = (i == 0) ? 8'h78 : (i == 1) ? 8'hff : (i == 2) ? 8'h82 : tmp[7:0];
      bus(1'b1, 4'h0, {24'h0, b});
      repeat (3) @(posedge core_clk);
      chk(frameCfg[7:2], fexp(b), "frame decode");
    end
    foreach (dv[i]) begin
      b = (i == 4) ? FlowXonPass : i[7:0];
      bus(1'b1, 4'h1, {24'h0, b});
      bus(1'b0, 4'h1, 32'h0);
      chk(rd[7:0], b, "flow code");
      tmp = (b == FlowXonPass) ? 3 : (b == 8'h03) ? 0 : b;
      chk(frameCfg[1:0], tmp[1:0], "flow decode");
    end
    $display("test framing done");
    // incoming acceptance per policy
    for (int i = 0; i < 7; i++) begin
      pol(ap[i]);
      modemCtrlIn <= AM[i];
      repeat (4) @(posedge core_clk);
      cmd(3);
      watch(3);
      chk(sAcc, AE[i], "accept");
      chk(sRef, !AE[i], "refuse");
      if (connActive === 1'b1) cmd(1);
    end
    modemCtrlIn <= 1'b0;
    pol(8'hc0);
    cmd(3);
    cmd(3);
    watch(3);
    chk(sAcc, 1'b0, "busy accept");
    cmd(1);
    $display("test accept done");
    // character responses, then overridden and quiet cases
    pol(8'hd0);
    for (int k = 0; k < 3; k++) begin
      cmd(k);
      watch(6);
      chk(sResp, 1'b1, "char sent");
      chk(sChar, (k == 0) ? RespConnected : (k == 1) ? RespDisconnected : RespUnreachable,
          "char value");
    end
    for (int k = 0; k < 2; k++) begin
      pol(k == 0 ? 8'h16 : 8'hc0);
      cmd(0);
      watch(6);
      chk(sResp, 1'b0, "quiet");
      chk(sShow, k == 0, "show addr");
      cmd(1);
    end
    $display("test response done");
    // active startup modes, partner alternates prompt and slow
    for (int i = 0; i < 7; i++) begin
      pol(sp[i]);
      slow <= i[0];
      if (i < 6) begin
        rxChar <= sc[i];
        rxCharValid <= 1'b1;
        @(posedge core_clk);
        rxCharValid <= 1'b0;
      end else begin
        modemCtrlIn <= 1'b1;
      end
      watch(8);
      chk(sStart, SE[i], "startup");
      repeat (4) @(posedge core_clk);
      if (connActive === 1'b1) cmd(1);
    end
    slow <= 1'b0;
    bus(1'b1, 4'h3, 32'hc5);
    watch(6);
    chk(sStart, 1'b1, "autostart");
    cmd(1);
    $display("test startup done");
    // local port and automatic source port
    bus(1'b1, 4'h2, 32'h3039);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd[15:0], 16'h3039, "port readback");
    pol(8'hc1);
    bus(1'b1, 4'h2, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(srcPort, AutoPortLow, "auto port start");
    repeat (9999) cmd(0);
    repeat (3) @(posedge core_clk);
    chk(srcPort, AutoPortHigh, "auto port top");
    cmd(0);
    repeat (3) @(posedge core_clk);
    chk(srcPort, AutoPortLow, "auto port wrap");
    cmd(0);
    cmd(1);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(srcPort, PortDefaultCh1, "second reset port");
    bus(1'b0, 4'h5, 32'h0);
    chk(rd[31:16], AutoPortLow, "port after reset");
    $display("test port done");
    complete_run();
  end
endmodule // tb_top

bind sccd_channel_config sccd_cfg_asserts i_chk (.core_clk, .rstn, .avsAddress, .avsWrite,
  .avsWritedata, .avsByteenable, .avsWaitrequest, .modemCtrlIn, .rxCharValid, .rxChar,
  .respValid, .respChar, .incomingReq, .connActive, .connEvent, .outConnOpen,
  .incomingAccept, .incomingRefuse, .connectStart, .srcPort, .frameCfg, .policyCfg);
